// File: logic/lpm_pkg.sv
// Constants and types shared by the low-power and reset-status logic.
package lpm_pkg;
	// ==========================================================
	// Register offsets on the plain register port.
	localparam logic [3:0] OFS_RESET_STATUS = 4'h0;
	localparam logic [3:0] OFS_CONFIG_ONE   = 4'h1;
	localparam logic [3:0] OFS_BREAK_STATUS = 4'h2;
	localparam logic [3:0] OFS_MODE_STATUS  = 4'h3;
	// ==========================================================
	// Field positions of the configuration register.
	localparam int CFG_WDOG_DIS  = 0;
	localparam int CFG_SHORT_REC = 1;
	localparam int CFG_OSC_KEEP  = 2;
	localparam int CFG_TRIP_SEL  = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// ==========================================================
	// Field positions of the reset-source status register.
	localparam int RS_POR   = 7;
	localparam int RS_PIN   = 6;
	localparam int RS_WDOG  = 5;
	localparam int RS_ILOP  = 4;
	localparam int RS_ILAD  = 3;
	localparam int RS_MON   = 2;
	localparam int RS_LOWV  = 1;
	localparam logic [7:0] RS_RESET = 8'h80;
	// Break status register field.
	localparam int BS_LOWPWR = 1;
	// ==========================================================
	// Recovery counts in quadruple-rate clock cycles.
	localparam int REC_LONG  = 4096;
	localparam int REC_SHORT = 32;
	localparam int CNT_W     = 13;
	typedef enum logic [1:0] {
		RUN,
		WAITING,
		STOPPED,
		RECOVER
	} mode_t;
endpackage

// File: logic/lowpower_ctrl.sv
// Low-power mode control and reset-source status registers.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - In wait mode the processor clocks are held inactive.
// - Reset, or break in emulation, ends wait mode.
// - Break during wait sets the break-in-low-power flag.
// - Watchdog keeps running in wait when its disable bit is zero.
// - Stop entry resets the recovery counter and disables system clocks.
// - Any module interrupt request ends stop mode.
// - Interrupt stacking starts only after the full recovery time.
// - Reset or break also ends stop mode.
// - Stop gates both double-rate and quad-rate bus clocks.
// - Oscillator keep-alive bit keeps double-rate clock running in stop.
// - Recovery is 4096 cycles, or 32 with short-recovery bit set.
// - Counter held reset from stop until recovery, then times it.
// - Reading reset-source status clears all its flags afterward.
// - Power-on reset sets its flag and clears all others except a low-voltage flag raised in the same cycle.
// - Other reset sources set only their own flag.
// - Several reset-cause flags may be set together.
// - Trip select bit is cleared only by power-on reset; here a configuration register write with that bit zero also clears it.
// - Stop exit by low-voltage reset uses the long recovery.
module lowpower_ctrl #(
	parameter int REC_LONG_CYCLES  = lpm_pkg::REC_LONG,
	parameter int REC_SHORT_CYCLES = lpm_pkg::REC_SHORT
) (
	input  wire logic       CLOCK,
	input  wire logic       RESETN,
	input  wire logic       POR_EVENT,
	input  wire logic [5:0] RESET_EVENTS,
	input  wire logic       WAIT_EXEC,
	input  wire logic       STOP_EXEC,
	input  wire logic       IRQ_PENDING,
	input  wire logic       BREAK_EVENT,
	input  wire logic       EMULATION,
	input  wire logic [3:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	output logic            CPU_CLK_EN,
	output logic            BUS_X2_EN,
	output logic            BUS_X4_EN,
	output logic            WDOG_EN,
	output logic            STACK_GO,
	output logic            TRIP_SELECT
);

	// Every check below samples on the rising edge and rests in reset.
	default clocking chk_cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);

	// ==========================================================
	// State.
	typedef struct packed {
		lpm_pkg::mode_t           mode;
		logic [lpm_pkg::CNT_W-1:0] cnt;
		logic [lpm_pkg::CNT_W-1:0] target;
		logic                     stack;
		logic [7:0]               cfg;
		logic [7:0]               rsts;
		logic                     brk_flag;
		logic                     clr_rsts;
		logic [7:0]               rdata;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic   any_rst;
	logic   wake;

	assign any_rst = POR_EVENT | (|RESET_EVENTS);

	// ==========================================================
	// Next state.
	always_comb begin
		s_d = s_q;
		s_d.stack = 1'b0;
		s_d.rdata = 8'h00;
		wake = IRQ_PENDING | BREAK_EVENT;
		// Flags are cleared the cycle after the read, before new sets.
		if (s_q.clr_rsts) begin
			s_d.rsts = 8'h00;
		end
		s_d.clr_rsts = 1'b0;
		if (RD) begin
			unique case (ADDR)
				lpm_pkg::OFS_RESET_STATUS: begin
					s_d.rdata = s_q.rsts;
					s_d.clr_rsts = 1'b1;
				end
				lpm_pkg::OFS_CONFIG_ONE:   s_d.rdata = s_q.cfg;
				lpm_pkg::OFS_BREAK_STATUS: begin
					s_d.rdata = 8'h00;
					s_d.rdata[lpm_pkg::BS_LOWPWR] = s_q.brk_flag;
				end
				lpm_pkg::OFS_MODE_STATUS:  s_d.rdata = {6'h00, s_q.mode};
				default:                   s_d.rdata = 8'h00;
			endcase
		end
		if (WR && ADDR == lpm_pkg::OFS_CONFIG_ONE) begin
			s_d.cfg = WDATA;
		end
		if (WR && ADDR == lpm_pkg::OFS_BREAK_STATUS
			&& !WDATA[lpm_pkg::BS_LOWPWR]) begin
			s_d.brk_flag = 1'b0;
		end
		unique case (s_q.mode)
			lpm_pkg::RUN: begin
				if (WAIT_EXEC) begin
					s_d.mode = lpm_pkg::WAITING;
				end else if (STOP_EXEC) begin
					s_d.mode = lpm_pkg::STOPPED;
					s_d.cnt = '0;
				end
			end
			lpm_pkg::WAITING: begin
				if (BREAK_EVENT) begin
					s_d.brk_flag = 1'b1;
				end
				if (IRQ_PENDING || (BREAK_EVENT && EMULATION)) begin
					s_d.mode = lpm_pkg::RUN;
				end
			end
			lpm_pkg::STOPPED: begin
				s_d.cnt = '0;
				if (BREAK_EVENT) begin
					s_d.brk_flag = 1'b1;
				end
				if (wake) begin
					s_d.mode = lpm_pkg::RECOVER;
					s_d.target = s_q.cfg[lpm_pkg::CFG_SHORT_REC]
						? lpm_pkg::CNT_W'(REC_SHORT_CYCLES)
						: lpm_pkg::CNT_W'(REC_LONG_CYCLES);
				end
			end
			lpm_pkg::RECOVER: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == s_q.target - 1'b1) begin
					s_d.mode = lpm_pkg::RUN;
					s_d.stack = 1'b1;
				end
			end
		endcase
		// Any non-power-on reset while stopped takes the long path.
		if (|RESET_EVENTS && (s_q.mode == lpm_pkg::STOPPED
			|| s_q.mode == lpm_pkg::RECOVER)) begin
			s_d.mode = lpm_pkg::RECOVER;
			s_d.cnt = '0;
			// A reset on the last recovery cycle must not let stacking start.
			s_d.stack = 1'b0;
			s_d.target = lpm_pkg::CNT_W'(REC_LONG_CYCLES);
		end else if (|RESET_EVENTS) begin
			s_d.mode = lpm_pkg::RUN;
		end
		// Reset flags are set last so a set beats a pending clear.
		s_d.rsts[lpm_pkg::RS_PIN:lpm_pkg::RS_LOWV] =
			s_d.rsts[lpm_pkg::RS_PIN:lpm_pkg::RS_LOWV]
			| RESET_EVENTS;
		if (POR_EVENT) begin
			s_d = '0;
			s_d.rsts = lpm_pkg::RS_RESET;
			s_d.rsts[lpm_pkg::RS_LOWV] = RESET_EVENTS[0];
			s_d.cfg = lpm_pkg::CFG_RESET;
		end else if (any_rst) begin
			// Trip select survives every reset but power-on.
			s_d.cfg = {s_q.cfg[7:4], s_q.cfg[lpm_pkg::CFG_TRIP_SEL],
				3'h0};
			s_d.brk_flag = 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			s_q <= '0;
			s_q.rsts <= lpm_pkg::RS_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs.
	assign RDATA = s_q.rdata;
	assign CPU_CLK_EN = (s_q.mode == lpm_pkg::RUN);
	assign BUS_X4_EN = (s_q.mode != lpm_pkg::STOPPED);
	assign BUS_X2_EN = (s_q.mode != lpm_pkg::STOPPED)
		|| s_q.cfg[lpm_pkg::CFG_OSC_KEEP];
	// Apart from its disable bit, the watchdog is halted only in stop, where its clock is gone.
	assign WDOG_EN = !s_q.cfg[lpm_pkg::CFG_WDOG_DIS]
		&& s_q.mode != lpm_pkg::STOPPED;
	assign STACK_GO = s_q.stack;
	assign TRIP_SELECT = s_q.cfg[lpm_pkg::CFG_TRIP_SEL];

	// ==========================================================
	// Checks.
	// Wait mode: only the processor clock stops, other modules run on.
	a_wait_cpu_off: assert property (
		s_q.mode == lpm_pkg::WAITING
		|-> !CPU_CLK_EN)
		else $error("cpu clock on in wait");

	a_wait_bus_on: assert property (
		s_q.mode == lpm_pkg::WAITING
		|-> BUS_X4_EN && BUS_X2_EN)
		else $error("bus clocks off in wait");

	a_wait_wdog_on: assert property (
		s_q.mode == lpm_pkg::WAITING
		&& !s_q.cfg[lpm_pkg::CFG_WDOG_DIS] |-> WDOG_EN)
		else $error("watchdog off in wait");

	a_wait_irq_exit: assert property (
		s_q.mode == lpm_pkg::WAITING && IRQ_PENDING && !POR_EVENT
		|=> CPU_CLK_EN)
		else $error("wait not left on interrupt");

	a_emu_brk_exit: assert property (
		s_q.mode == lpm_pkg::WAITING && BREAK_EVENT && EMULATION
		|=> CPU_CLK_EN)
		else $error("wait not left on emulation break");

	a_wait_rst_exit: assert property (
		s_q.mode == lpm_pkg::WAITING && any_rst
		|=> s_q.mode == lpm_pkg::RUN)
		else $error("wait not left on reset");

	a_wait_brk_flag: assert property (
		s_q.mode == lpm_pkg::WAITING && BREAK_EVENT && !any_rst
		|=> s_q.brk_flag)
		else $error("break flag not set");

	// Stop mode: the counter idles at zero until a wake source appears.
	a_stop_enter: assert property (
		s_q.mode == lpm_pkg::RUN && STOP_EXEC && !WAIT_EXEC && !any_rst
		|=> s_q.mode == lpm_pkg::STOPPED && s_q.cnt == '0 && !BUS_X4_EN)
		else $error("stop entry wrong");

	a_stop_clocks: assert property (
		s_q.mode == lpm_pkg::STOPPED |-> !BUS_X4_EN && s_q.cnt == '0
		&& BUS_X2_EN == s_q.cfg[lpm_pkg::CFG_OSC_KEEP])
		else $error("clocks not gated in stop");

	a_stop_x2_keep: assert property (
		s_q.mode == lpm_pkg::STOPPED && s_q.cfg[lpm_pkg::CFG_OSC_KEEP]
		|-> BUS_X2_EN)
		else $error("double-rate clock gated despite keep-alive");

	a_stop_wake: assert property (
		s_q.mode == lpm_pkg::STOPPED && wake && !POR_EVENT
		|=> s_q.mode == lpm_pkg::RECOVER)
		else $error("stop not left on wake");

	a_brk_stop_wake: assert property (
		s_q.mode == lpm_pkg::STOPPED && BREAK_EVENT && !POR_EVENT
		|=> s_q.mode == lpm_pkg::RECOVER)
		else $error("stop not left on break");

	a_por_stop_exit: assert property (
		s_q.mode != lpm_pkg::RUN && POR_EVENT
		|=> s_q.mode == lpm_pkg::RUN && CPU_CLK_EN)
		else $error("power-on reset did not end low power");

	a_wake_short: assert property (
		s_q.mode == lpm_pkg::STOPPED && wake && !any_rst
		&& s_q.cfg[lpm_pkg::CFG_SHORT_REC]
		|=> s_q.target == lpm_pkg::CNT_W'(REC_SHORT_CYCLES))
		else $error("short recovery length wrong");

	a_wake_long: assert property (
		s_q.mode == lpm_pkg::STOPPED && wake && !any_rst
		&& !s_q.cfg[lpm_pkg::CFG_SHORT_REC]
		|=> s_q.target == lpm_pkg::CNT_W'(REC_LONG_CYCLES))
		else $error("long recovery length wrong");

	a_lvi_long: assert property (
		RESET_EVENTS[0] && !POR_EVENT && s_q.mode == lpm_pkg::STOPPED
		|=> s_q.target == lpm_pkg::CNT_W'(REC_LONG_CYCLES))
		else $error("low-voltage exit not long");

	// Recovery: the processor stays halted until the count runs out, so
	// an interrupt never stacks on a clock that has not settled yet.
	a_recover_cpu_off: assert property (
		s_q.mode == lpm_pkg::RECOVER
		|-> !CPU_CLK_EN && !STACK_GO)
		else $error("processor running during recovery");

	a_recover_count: assert property (
		s_q.mode == lpm_pkg::RECOVER && !any_rst
		|=> s_q.cnt == $past(s_q.cnt) + 1'b1)
		else $error("recovery counter not counting");

	a_short_recover: assert property (
		s_q.mode == lpm_pkg::STOPPED && IRQ_PENDING && s_q.cfg[1]
		&& !any_rst ##1 !any_rst [*8] |-> !STACK_GO)
		else $error("stacking started early");

	a_stack_end: assert property (
		STACK_GO |-> $past(s_q.mode) == lpm_pkg::RECOVER
		&& $past(s_q.cnt) == $past(s_q.target) - 1'b1)
		else $error("stacking before recovery end");

	a_stack_one: assert property (
		STACK_GO
		|=> !STACK_GO)
		else $error("stacking pulse too long");

	// Reset-cause flags: sets always win over the clear after a read.
	a_por_flags: assert property (
		POR_EVENT |=> s_q.rsts[7] && s_q.rsts[6:2] == 5'h00
		&& !TRIP_SELECT)
		else $error("power-on flags wrong");

	a_read_clears: assert property (
		RD && ADDR == lpm_pkg::OFS_RESET_STATUS && !any_rst
		##1 !any_rst |=> s_q.rsts == 8'h00)
		else $error("status not cleared by read");

	a_rst_flag_set: assert property (
		|RESET_EVENTS && !POR_EVENT
		|=> (s_q.rsts[6:1] & $past(RESET_EVENTS)) == $past(RESET_EVENTS))
		else $error("reset cause flag not set");

	a_rst_keeps_others: assert property (
		|RESET_EVENTS && !POR_EVENT && !s_q.clr_rsts
		|=> s_q.rsts == ($past(s_q.rsts)
		| {1'b0, $past(RESET_EVENTS), 1'b0}))
		else $error("other reset flags disturbed");

	a_set_beats_clr: assert property (
		s_q.clr_rsts && |RESET_EVENTS && !POR_EVENT
		|=> s_q.rsts[6:1] == $past(RESET_EVENTS))
		else $error("flag lost to read clear");

	a_trip_kept: assert property (
		any_rst && !POR_EVENT
		|=> TRIP_SELECT == $past(TRIP_SELECT))
		else $error("trip select lost on reset");

	c_wait_exit: cover property (
		s_q.mode == lpm_pkg::WAITING ##1 s_q.mode == lpm_pkg::RUN);
	c_stop_stack: cover property (STACK_GO);
	c_multi_flag: cover property (s_q.rsts[7] && s_q.rsts[1]);
	c_brk_wait: cover property (s_q.mode == lpm_pkg::WAITING && BREAK_EVENT);
	c_rst_stop: cover property (s_q.mode == lpm_pkg::STOPPED && |RESET_EVENTS);

endmodule
`default_nettype wire

// File: tb/cpu_model.sv
// Processor-side model: executes low-power instructions, raises interrupts.
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
	input  wire logic clk,
	input  wire logic do_wait,
	input  wire logic do_stop,
	input  wire logic do_irq,
	input  wire logic clk_en,
	input  wire logic stack_go,
	output logic      wait_exec,
	output logic      stop_exec,
	output logic      irq
);
	// ==========================================================
	// Requests
	// A source holds its request until the processor runs again, so a
	// slow recovery keeps seeing a pending interrupt.
	always_ff @(posedge clk) begin
		wait_exec <= do_wait;
		stop_exec <= do_stop;
		if (do_irq)
			irq <= 1'h1;
		else if (clk_en || stack_go)
			irq <= 1'h0;
	end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for low-power control and reset-status flags.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int LONG = 64;
	logic       CLOCK = 1'h0, RESETN = 1'h0, POR_EVENT = 1'h0;
	logic       BREAK_EVENT = 1'h0, EMULATION = 1'h0, WR = 1'h0, RD = 1'h0;
	logic       do_wait = 1'h0, do_stop = 1'h0, do_irq = 1'h0;
	logic [5:0] RESET_EVENTS = 6'h00;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00, RDATA;
	logic       WAIT_EXEC, STOP_EXEC, IRQ_PENDING, CPU_CLK_EN, BUS_X2_EN;
	logic       BUS_X4_EN, WDOG_EN, STACK_GO, TRIP_SELECT;
	int         failures = 0, comparisons = 0;
	wire logic [7:0] outs = {2'h0, CPU_CLK_EN, BUS_X2_EN, BUS_X4_EN,
		WDOG_EN, STACK_GO, TRIP_SELECT};
	lowpower_ctrl #(.REC_LONG_CYCLES(LONG)) i_lowpower_ctrl (.CLOCK, .RESETN,
		.POR_EVENT, .RESET_EVENTS, .WAIT_EXEC, .STOP_EXEC, .IRQ_PENDING,
		.BREAK_EVENT, .EMULATION, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.CPU_CLK_EN, .BUS_X2_EN, .BUS_X4_EN, .WDOG_EN, .STACK_GO, .TRIP_SELECT);
	cpu_model i_cpu_model (.clk(CLOCK), .do_wait, .do_stop, .do_irq,
		.clk_en(CPU_CLK_EN), .stack_go(STACK_GO), .wait_exec(WAIT_EXEC),
		.stop_exec(STOP_EXEC), .irq(IRQ_PENDING));
	initial forever #25 CLOCK = ~CLOCK;
	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic after(input int n);
		repeat (n) @(posedge CLOCK);
		@(negedge CLOCK);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'h1;
		@(posedge CLOCK);
		WR <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'h1;
		@(posedge CLOCK);
		RD <= 1'h0;
		@(negedge CLOCK);
		chk("rdata", e, RDATA);
	endtask
	// Bits: por, six reset causes, break, wait, stop, interrupt.
	task automatic pulse(input logic [10:0] m);
		@(posedge CLOCK);
		{POR_EVENT, RESET_EVENTS, BREAK_EVENT, do_wait, do_stop, do_irq} <= m;
		@(posedge CLOCK);
		{POR_EVENT, RESET_EVENTS, BREAK_EVENT, do_wait, do_stop, do_irq} <= 11'h000;
	endtask
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_flags;
		chk("outs", 8'h3c, outs);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h80);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h00);
		wr(lpm_pkg::OFS_RESET_STATUS, 8'hff);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h00);
		rd(4'h9, 8'h00);
		pulse(11'h210);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h42);
		wr(lpm_pkg::OFS_CONFIG_ONE, 8'h08);
		pulse(11'h100);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h20);
		chk("outs", 8'h3d, outs);
		pulse(11'h410);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h82);
		chk("outs", 8'h3c, outs);
	endtask
	task automatic t_wait;
		pulse(11'h004);
		after(1);
		chk("outs", 8'h1c, outs);
		pulse(11'h008);
		after(1);
		chk("outs", 8'h1c, outs);
		rd(lpm_pkg::OFS_BREAK_STATUS, 8'h02);
		rd(lpm_pkg::OFS_MODE_STATUS, 8'h01);
		wr(lpm_pkg::OFS_BREAK_STATUS, 8'h00);
		rd(lpm_pkg::OFS_BREAK_STATUS, 8'h00);
		pulse(11'h001);
		after(1);
		chk("outs", 8'h3c, outs);
		wr(lpm_pkg::OFS_CONFIG_ONE, 8'h01);
		EMULATION <= 1'h1;
		pulse(11'h004);
		after(1);
		chk("outs", 8'h18, outs);
		pulse(11'h008);
		after(0);
		chk("outs", 8'h38, outs);
		EMULATION <= 1'h0;
		pulse(11'h004);
		after(1);
		pulse(11'h200);
		after(0);
		chk("outs", 8'h3c, outs);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h40);
	endtask
	// The recovery may not start while stopped, so 40 idle cycles pass first.
	task automatic t_stop(input logic [7:0] cfg, input logic [10:0] waker,
			input int n, input logic [7:0] sleep);
		int k;
		wr(lpm_pkg::OFS_CONFIG_ONE, cfg);
		pulse(11'h002);
		after(40);
		chk("outs", sleep, outs);
		rd(lpm_pkg::OFS_MODE_STATUS, 8'h02);
		pulse(waker);
		k = 0;
		do begin
			@(negedge CLOCK);
			k++;
		end while (STACK_GO !== 1'h1 && k < 200);
		chk("gap", 8'h01, {7'h00, k >= n && k <= n + 3});
		chk("outs", 8'h3e, outs);
	endtask
	initial begin
		fork
			begin
				repeat (3000) @(posedge CLOCK);
				failures++;
				give_verdict;
			end
		join_none
		repeat (2) @(posedge CLOCK);
		RESETN <= 1'h1;
		@(negedge CLOCK);
		t_flags;
		t_wait;
		t_stop(8'h02, 11'h001, 32, 8'h00);
		t_stop(8'h04, 11'h001, LONG, 8'h10);
		t_stop(8'h02, 11'h010, LONG, 8'h00);
		rd(lpm_pkg::OFS_RESET_STATUS, 8'h02);
		give_verdict;
	end
endmodule
`default_nettype wire
